// *** design/drs_pkg.sv ***
// constants and types shared by the run/jog/ramp-stop sequencer
package drs_pkg;
	localparam int CLK_KHZ = 25000;
	localparam int US_PER_MS = 1000;
	localparam int IN_W = 20;
	localparam int DEB_US = 100;
	localparam int DEB_CYC = DEB_US * CLK_KHZ / US_PER_MS;
	localparam int DEB_W = 12;
	localparam int UV_MS = 80;
	localparam int UV_CYC = UV_MS * CLK_KHZ;
	localparam int UV_W = 21;
	localparam int SPEED_W = 12;
	localparam int SPEED_STEPS = 4096;
	localparam int SET_W = 8;
	localparam int SET_MAX = 255;
	localparam int STEP_W = 20;
	localparam int PROD_W = STEP_W + SET_W;
	localparam int FAST_MIN_MS = 50;
	localparam int FAST_MAX_MS = 2000;
	localparam int SLOW_MIN_MS = 2000;
	localparam int SLOW_MAX_MS = 90000;
	localparam int FAST_MIN_STEP = int'(longint'(FAST_MIN_MS) * CLK_KHZ / SPEED_STEPS);
	localparam int FAST_MAX_STEP = int'(longint'(FAST_MAX_MS) * CLK_KHZ / SPEED_STEPS);
	localparam int SLOW_MIN_STEP = int'(longint'(SLOW_MIN_MS) * CLK_KHZ / SPEED_STEPS);
	localparam int SLOW_MAX_STEP = int'(longint'(SLOW_MAX_MS) * CLK_KHZ / SPEED_STEPS);
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_REFERENCE = 8'h00;
	localparam logic [ADDR_W-1:0] REG_JOG_SPEED = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TIME_SETTING = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
	localparam logic [SPEED_W-1:0] REFERENCE_RST = 12'h000;
	localparam logic [SPEED_W-1:0] JOG_SPEED_RST = 12'h000;
	localparam logic [SET_W-1:0] TIME_SETTING_RST = 8'h80;
	localparam int TIME_B_LSB = 8;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_RUN = 2;
	localparam int STAT_JOG = 3;
	localparam int STAT_ENABLE = 4;
	localparam int STAT_BUS_FAULT = 5;
	localparam int STAT_SUPPLY_FAULT = 6;
	localparam int STAT_IOC_FAULT = 7;
	localparam int STAT_DIGITAL = 8;
	localparam int STAT_SPEED_LSB = 16;
	typedef enum logic [1:0] {POS_INTERNAL = 2'b00, POS_RESET = 2'b01, POS_TRAP = 2'b10}
		drs_reset_pos_t;
	typedef enum logic [1:0] {ST_STOPPED, ST_RUN, ST_JOG, ST_RAMP_STOP} drs_mode_t;
endpackage : drs_pkg

// *** design/drs_debounce.sv ***
// per-bit synchroniser and stability filter for slow operator and status inputs
`timescale 1ns/1ps
module drs_debounce #(
	parameter int WIDTH = drs_pkg::IN_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// raw and filtered levels
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] clean_o
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic meta;
			logic sync;
			logic [drs_pkg::DEB_W-1:0] cnt;
			logic [drs_pkg::DEB_W-1:0] next_cnt;
			logic next_clean;
			always_comb begin
				next_cnt = '0;
				next_clean = clean_o[gi];
				if (sync != clean_o[gi]) begin
					next_cnt = cnt + 1'b1;
					if (cnt == drs_pkg::DEB_W'(drs_pkg::DEB_CYC - 1)) begin
						next_clean = sync;
						next_cnt = '0;
					end
				end
			end
			always_ff @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta <= 1'b0;
					sync <= 1'b0;
					cnt <= '0;
					clean_o[gi] <= 1'b0;
				end else begin
					meta <= raw_i[gi];
					sync <= meta;
					cnt <= next_cnt;
					clean_o[gi] <= next_clean;
				end
			end
		end
	endgenerate
endmodule : drs_debounce

// *** design/drs_ramp.sv ***
// constant-slope speed ramp: one speed step per programmable interval
`timescale 1ns/1ps
module drs_ramp (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// control
	input wire logic clear_i,
	input wire logic [drs_pkg::SPEED_W-1:0] target_i,
	input wire logic [drs_pkg::STEP_W-1:0] up_interval_i,
	input wire logic [drs_pkg::STEP_W-1:0] down_interval_i,
	// ramp output
	output logic [drs_pkg::SPEED_W-1:0] speed_o
);
	logic [drs_pkg::STEP_W-1:0] cnt;
	logic [drs_pkg::STEP_W-1:0] next_cnt;
	logic [drs_pkg::SPEED_W-1:0] next_speed;
	logic [drs_pkg::STEP_W-1:0] interval;

	// every step in one direction takes the same time, so partial changes scale with their size
	always_comb begin
		interval = (speed_o < target_i) ? up_interval_i : down_interval_i;
		next_cnt = cnt + 1'b1;
		next_speed = speed_o;
		if (clear_i) begin
			next_cnt = '0;
			next_speed = '0;
		end else if (speed_o == target_i) begin
			next_cnt = '0;
		end else if (cnt >= interval) begin
			next_cnt = '0;
			next_speed = (speed_o < target_i) ? speed_o + 1'b1 : speed_o - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= '0;
			speed_o <= '0;
		end else begin
			cnt <= next_cnt;
			speed_o <= next_speed;
		end
	end
endmodule : drs_ramp

// *** design/drs_sequencer.sv ***
// run/jog/ramp-stop sequencer with interlocks, fault latches, indicators and apb registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - forced-digital jumper position keeps digital mode; otherwise digital input decides.
// - reset jumper internal: a stop action clears latched faults.
// - reset jumper trap position: stop does not clear latched faults.
// - reset jumper middle clears faults, blocks running and withholds enable.
// - coast jumper installed: run or jog end enters ramp stop toward zero.
// - coast jumper removed: no ramp stop, drive disabled when run/jog ends.
// - ramp-range jumper picks 2-90 s or 50 ms-2 s full-scale ramp.
// - ramps have constant slope; partial changes take proportional time.
// - run/jog only with emergency stop energized; removal stops at once.
// - start lights run indicator and closes run contact even without e-stop.
// - with e-stop energized, run mode lasts while start stays energized.
// - momentary start seals in only while stop-circuit hold is energized.
// - dropping hold while running ends run and enters selected stop behaviour.
// - jog starts jog mode, lights jog indicator; run indicator and contact stay off.
// - jog overrides run; releasing jog returns to run and ramps to reference.
// - enable request raised in run or jog mode.
// - enable withheld without bus ready or without emergency stop.
// - enable withheld while any latched trip is active.
// - bus indicator red at power-up, green when charged, red on fault while disabled.
// - each commutation indicator on for south pole, off for north.
// - speed-sensor indicator green for sensor a, red for sensor b, both, or off.
// - enable indicator lit fault-free in run, jog or ramp stop; off on undervoltage.
// - enable drops once run, jog and ramp stop are all inactive.
// - undervoltage timer trips bus fault after 80 ms below 85 percent.
module drs_sequencer #(
	parameter int UV_TRIP_CYC = drs_pkg::UV_CYC,
	parameter int FAST_MIN_STEP = drs_pkg::FAST_MIN_STEP,
	parameter int FAST_MAX_STEP = drs_pkg::FAST_MAX_STEP,
	parameter int SLOW_MIN_STEP = drs_pkg::SLOW_MIN_STEP,
	parameter int SLOW_MAX_STEP = drs_pkg::SLOW_MAX_STEP
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [drs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// operator inputs, high = energized
	input wire logic estop_ok_i,
	input wire logic start_i,
	input wire logic stop_hold_i,
	input wire logic jog_i,
	input wire logic digital_mode_i,
	// board jumpers
	input wire logic mode_select_jumper_i,
	input wire logic coast_select_jumper_i,
	input wire logic ramp_range_jumper_i,
	input wire logic [1:0] fault_reset_jumper_i,
	// power stage status
	input wire logic bus_charged_i,
	input wire logic bus_low_i,
	input wire logic bus_over_i,
	input wire logic supply_low_i,
	input wire logic overcurrent_i,
	// position sensors, high = south pole
	input wire logic commutation_sensor_a_i,
	input wire logic commutation_sensor_b_i,
	input wire logic commutation_sensor_c_i,
	input wire logic speed_sensor_a_i,
	input wire logic speed_sensor_b_i,
	// drive control outputs
	output logic enable_request_o,
	output logic drive_enable_o,
	output logic run_contact_o,
	output logic digital_mode_o,
	output logic ramp_stop_o,
	output logic [drs_pkg::SPEED_W-1:0] speed_o,
	// indicators
	output logic run_indicator_o,
	output logic jog_indicator_o,
	output logic drive_enable_indicator_o,
	output logic bus_red_o,
	output logic bus_green_o,
	output logic [2:0] commutation_indicator_o,
	output logic speed_sensor_indicator_green_o,
	output logic speed_sensor_indicator_red_o,
	output logic bus_voltage_fault_o,
	output logic supply_loss_fault_o,
	output logic overcurrent_trip_o
);
	logic [drs_pkg::IN_W-1:0] clean;
	logic estop_ok;
	logic start_in;
	logic hold_in;
	logic jog_in;
	logic digital_in;
	logic mode_jp;
	logic coast_jp;
	logic ramp_jp;
	logic [1:0] reset_jp;
	logic charged;
	logic bus_low;
	logic bus_over;
	logic supply_low;
	logic ioc_in;
	logic [2:0] comm;
	logic spd_a;
	logic spd_b;

	drs_debounce #(
		.WIDTH(drs_pkg::IN_W)
	) u_debounce (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.raw_i({estop_ok_i, start_i, stop_hold_i, jog_i, digital_mode_i, mode_select_jumper_i,
			coast_select_jumper_i, ramp_range_jumper_i, fault_reset_jumper_i, bus_charged_i,
			bus_low_i, bus_over_i, supply_low_i, overcurrent_i, commutation_sensor_c_i,
			commutation_sensor_b_i, commutation_sensor_a_i, speed_sensor_a_i, speed_sensor_b_i}),
		.clean_o(clean)
	);

	assign {estop_ok, start_in, hold_in, jog_in, digital_in, mode_jp, coast_jp, ramp_jp, reset_jp,
		charged, bus_low, bus_over, supply_low, ioc_in, comm, spd_a, spd_b} = clean;

	// reset jumper decode; the unused code is treated as the middle position to stay safe
	logic pos_reset;
	logic pos_internal;
	assign pos_internal = reset_jp == drs_pkg::POS_INTERNAL;
	assign pos_reset = !pos_internal && reset_jp != drs_pkg::POS_TRAP;

	// run seal-in and stop action
	logic run_sealed;
	logic next_run_sealed;
	logic hold_q;
	logic run_on;
	logic stop_action;
	always_comb begin
		run_on = start_in | (run_sealed & hold_in);
		next_run_sealed = run_on;
		stop_action = hold_q & !hold_in;
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_sealed <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			run_sealed <= next_run_sealed;
			hold_q <= hold_in;
		end
	end

	// fault latches and undervoltage timer; a new set wins over a clear in the same cycle
	logic [drs_pkg::UV_W-1:0] uv_cnt;
	logic [drs_pkg::UV_W-1:0] next_uv_cnt;
	logic bus_fault;
	logic supply_fault;
	logic ioc_fault;
	logic charged_seen;
	logic next_bus_fault;
	logic next_supply_fault;
	logic next_ioc_fault;
	logic next_charged_seen;
	logic uv_expired;
	logic fault_clear;
	logic any_fault;
	always_comb begin
		next_uv_cnt = '0;
		uv_expired = 1'b0;
		if (bus_low) begin
			next_uv_cnt = uv_cnt;
			if (uv_cnt == drs_pkg::UV_W'(UV_TRIP_CYC - 1)) begin
				uv_expired = 1'b1;
			end else begin
				next_uv_cnt = uv_cnt + 1'b1;
			end
		end
		fault_clear = pos_reset | (pos_internal & stop_action);
		next_charged_seen = charged_seen | charged;
		next_bus_fault = bus_over | uv_expired | (charged_seen & !charged)
			| (bus_fault & !fault_clear);
		next_supply_fault = supply_low | (supply_fault & !fault_clear);
		next_ioc_fault = ioc_in | (ioc_fault & !fault_clear);
		any_fault = bus_fault | supply_fault | ioc_fault;
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			uv_cnt <= '0;
			bus_fault <= 1'b0;
			supply_fault <= 1'b0;
			ioc_fault <= 1'b0;
			charged_seen <= 1'b0;
		end else begin
			uv_cnt <= next_uv_cnt;
			bus_fault <= next_bus_fault;
			supply_fault <= next_supply_fault;
			ioc_fault <= next_ioc_fault;
			charged_seen <= next_charged_seen;
		end
	end

	// operating mode
	drs_pkg::drs_mode_t state;
	drs_pkg::drs_mode_t next_state;
	logic [drs_pkg::SPEED_W-1:0] ramp_speed;
	always_comb begin
		next_state = state;
		if (!estop_ok || pos_reset) begin
			next_state = drs_pkg::ST_STOPPED;
		end else if (jog_in) begin
			next_state = drs_pkg::ST_JOG;
		end else if (run_on) begin
			next_state = drs_pkg::ST_RUN;
		end else begin
			unique case (state)
				drs_pkg::ST_RUN, drs_pkg::ST_JOG: begin
					next_state = coast_jp ? drs_pkg::ST_RAMP_STOP : drs_pkg::ST_STOPPED;
				end
				drs_pkg::ST_RAMP_STOP: begin
					if (ramp_speed == '0) begin
						next_state = drs_pkg::ST_STOPPED;
					end
				end
				drs_pkg::ST_STOPPED: begin
					next_state = drs_pkg::ST_STOPPED;
				end
			endcase
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= drs_pkg::ST_STOPPED;
		end else begin
			state <= next_state;
		end
	end

	// registers written over apb
	logic [drs_pkg::SPEED_W-1:0] reference;
	logic [drs_pkg::SPEED_W-1:0] jog_speed;
	logic [drs_pkg::SET_W-1:0] time_setting_a;
	logic [drs_pkg::SET_W-1:0] time_setting_b;

	// ramp interval per speed step from the range jumper and the time setting
	function automatic logic [drs_pkg::STEP_W-1:0] step_of(input logic [drs_pkg::SET_W-1:0] s,
		input logic slow);
		logic [drs_pkg::PROD_W-1:0] lo;
		logic [drs_pkg::PROD_W-1:0] span;
		logic [drs_pkg::PROD_W-1:0] prod;
		lo = slow ? drs_pkg::PROD_W'(SLOW_MIN_STEP) : drs_pkg::PROD_W'(FAST_MIN_STEP);
		span = slow ? drs_pkg::PROD_W'(SLOW_MAX_STEP - SLOW_MIN_STEP)
			: drs_pkg::PROD_W'(FAST_MAX_STEP - FAST_MIN_STEP);
		prod = lo + span * drs_pkg::PROD_W'(s) / drs_pkg::PROD_W'(drs_pkg::SET_MAX);
		return prod[drs_pkg::STEP_W-1:0];
	endfunction : step_of

	logic [drs_pkg::SPEED_W-1:0] target;
	logic [drs_pkg::STEP_W-1:0] up_interval;
	logic [drs_pkg::STEP_W-1:0] down_interval;
	always_comb begin
		unique case (state)
			drs_pkg::ST_RUN: target = reference;
			drs_pkg::ST_JOG: target = jog_speed;
			drs_pkg::ST_RAMP_STOP, drs_pkg::ST_STOPPED: target = '0;
		endcase
		up_interval = step_of(time_setting_a, ramp_jp);
		down_interval = step_of(time_setting_b, ramp_jp);
	end

	// coasting drops the command to zero at once, the motor runs down on its own
	drs_ramp u_ramp (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.clear_i(state == drs_pkg::ST_STOPPED),
		.target_i(target),
		.up_interval_i(up_interval),
		.down_interval_i(down_interval),
		.speed_o(ramp_speed)
	);

	// registered outputs
	logic active;
	logic enable_ok;
	logic next_enable;
	logic next_bus_green;
	always_comb begin
		active = state != drs_pkg::ST_STOPPED;
		enable_ok = estop_ok & charged & !any_fault & !pos_reset;
		next_enable = active & enable_ok;
		next_bus_green = charged & !(bus_fault & !drive_enable_o);
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable_request_o <= 1'b0;
			drive_enable_o <= 1'b0;
			drive_enable_indicator_o <= 1'b0;
			run_contact_o <= 1'b0;
			run_indicator_o <= 1'b0;
			jog_indicator_o <= 1'b0;
			digital_mode_o <= 1'b0;
			ramp_stop_o <= 1'b0;
			speed_o <= '0;
			bus_red_o <= 1'b1;
			bus_green_o <= 1'b0;
			commutation_indicator_o <= '0;
			speed_sensor_indicator_green_o <= 1'b0;
			speed_sensor_indicator_red_o <= 1'b0;
			bus_voltage_fault_o <= 1'b0;
			supply_loss_fault_o <= 1'b0;
			overcurrent_trip_o <= 1'b0;
		end else begin
			enable_request_o <= state == drs_pkg::ST_RUN || state == drs_pkg::ST_JOG;
			drive_enable_o <= next_enable;
			drive_enable_indicator_o <= next_enable;
			run_contact_o <= run_on;
			run_indicator_o <= run_on;
			jog_indicator_o <= state == drs_pkg::ST_JOG;
			digital_mode_o <= mode_jp | digital_in;
			ramp_stop_o <= state == drs_pkg::ST_RAMP_STOP;
			speed_o <= ramp_speed;
			bus_red_o <= !next_bus_green;
			bus_green_o <= next_bus_green;
			commutation_indicator_o <= comm;
			speed_sensor_indicator_green_o <= spd_a;
			speed_sensor_indicator_red_o <= spd_b;
			bus_voltage_fault_o <= bus_fault;
			supply_loss_fault_o <= supply_fault;
			overcurrent_trip_o <= ioc_fault;
		end
	end

	// apb slave: one wait-free access phase, read data captured in the setup cycle
	logic setup;
	logic wr_en;
	logic mapped;
	logic [31:0] status;
	logic [31:0] rdata;
	logic [drs_pkg::SPEED_W-1:0] next_reference;
	logic [drs_pkg::SPEED_W-1:0] next_jog_speed;
	logic [drs_pkg::SET_W-1:0] next_time_a;
	logic [drs_pkg::SET_W-1:0] next_time_b;
	always_comb begin
		setup = psel & !penable;
		wr_en = psel & penable & pready & pwrite;
		status = '0;
		status[drs_pkg::STAT_MODE_LSB +: 2] = state;
		status[drs_pkg::STAT_RUN] = run_indicator_o;
		status[drs_pkg::STAT_JOG] = jog_indicator_o;
		status[drs_pkg::STAT_ENABLE] = drive_enable_o;
		status[drs_pkg::STAT_BUS_FAULT] = bus_fault;
		status[drs_pkg::STAT_SUPPLY_FAULT] = supply_fault;
		status[drs_pkg::STAT_IOC_FAULT] = ioc_fault;
		status[drs_pkg::STAT_DIGITAL] = digital_mode_o;
		status[drs_pkg::STAT_SPEED_LSB +: drs_pkg::SPEED_W] = ramp_speed;
		mapped = 1'b1;
		rdata = '0;
		unique case (paddr)
			drs_pkg::REG_REFERENCE: rdata = 32'(reference);
			drs_pkg::REG_JOG_SPEED: rdata = 32'(jog_speed);
			drs_pkg::REG_TIME_SETTING: rdata = 32'({time_setting_b, time_setting_a});
			drs_pkg::REG_STATUS: rdata = status;
			default: mapped = 1'b0;
		endcase
		next_reference = reference;
		next_jog_speed = jog_speed;
		next_time_a = time_setting_a;
		next_time_b = time_setting_b;
		if (wr_en && paddr == drs_pkg::REG_REFERENCE) begin
			next_reference = pwdata[drs_pkg::SPEED_W-1:0];
		end
		if (wr_en && paddr == drs_pkg::REG_JOG_SPEED) begin
			next_jog_speed = pwdata[drs_pkg::SPEED_W-1:0];
		end
		if (wr_en && paddr == drs_pkg::REG_TIME_SETTING) begin
			next_time_a = pwdata[drs_pkg::SET_W-1:0];
			next_time_b = pwdata[drs_pkg::TIME_B_LSB +: drs_pkg::SET_W];
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reference <= drs_pkg::REFERENCE_RST;
			jog_speed <= drs_pkg::JOG_SPEED_RST;
			time_setting_a <= drs_pkg::TIME_SETTING_RST;
			time_setting_b <= drs_pkg::TIME_SETTING_RST;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			reference <= next_reference;
			jog_speed <= next_jog_speed;
			time_setting_a <= next_time_a;
			time_setting_b <= next_time_b;
			prdata <= (setup && !pwrite) ? rdata : '0;
			pready <= setup;
			pslverr <= setup & !mapped;
		end
	end
endmodule : drs_sequencer

// *** testbench/drs_panel.sv ***
// behavioural operator panel, jumpers and power stage status with contact bounce
`timescale 1ns/1ps
module drs_panel (
	// clock
	input wire logic clock_i,
	// wanted and bouncing levels
	input wire logic [19:0] want_i,
	output logic [19:0] raw_o
);
	logic [19:0] last = 20'h0_0000;
	logic [19:0] chg = 20'h0_0000;
	logic [4:0] cnt = 5'h00;
	// real contacts chatter after each change, so the filter has work to do
	always @(posedge clock_i) begin
		last <= want_i;
		if (want_i != last) begin
			cnt <= 5'h14;
			chg <= want_i ^ last;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
		raw_o <= (cnt != 5'h00 && cnt[0]) ? (want_i ^ chg) : want_i;
	end
endmodule : drs_panel

// *** testbench/drs_sequencer_asserts.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module drs_sequencer_asserts (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// drive and indicators
	input wire logic enable_request_o,
	input wire logic drive_enable_o,
	input wire logic drive_enable_indicator_o,
	input wire logic run_contact_o,
	input wire logic run_indicator_o,
	input wire logic jog_indicator_o,
	input wire logic ramp_stop_o,
	input wire logic bus_red_o,
	input wire logic bus_green_o,
	input wire logic bus_voltage_fault_o,
	input wire logic supply_loss_fault_o,
	input wire logic overcurrent_trip_o,
	input wire logic [11:0] speed_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_enable_needs_mode: assert property (drive_enable_o |-> enable_request_o || ramp_stop_o)
		else $error("enable without run, jog or ramp stop");
	a_trip_blocks_enable: assert property ((bus_voltage_fault_o || supply_loss_fault_o
		|| overcurrent_trip_o) [*3] |-> !drive_enable_o) else $error("enable during trip");
	a_enable_ind_match: assert property (drive_enable_indicator_o == drive_enable_o)
		else $error("enable indicator differs");
	a_run_contact_match: assert property (run_contact_o == run_indicator_o)
		else $error("run contact differs from indicator");
	a_bus_colour_one: assert property (bus_red_o != bus_green_o)
		else $error("bus indicator colours");
	a_ramp_excl_run: assert property (ramp_stop_o |-> !enable_request_o)
		else $error("ramp stop with run or jog");
	a_jog_requests: assert property (jog_indicator_o |-> enable_request_o)
		else $error("jog without enable request");
	a_speed_slope: assert property ($changed(speed_o) && speed_o != 12'h000
		|-> 12'(speed_o - $past(speed_o)) inside {12'h001, 12'hfff})
		else $error("speed step not one");
	a_apb_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready timing");
	a_apb_bad_addr: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04,
		8'h08, 8'h0c})) else $error("pslverr on address");
endmodule : drs_sequencer_asserts

bind drs_sequencer drs_sequencer_asserts drs_sequencer_asserts_i (.clock_i, .arst_n_i, .psel,
	.penable, .paddr, .pready, .pslverr, .enable_request_o, .drive_enable_o,
	.drive_enable_indicator_o, .run_contact_o, .run_indicator_o, .jog_indicator_o,
	.ramp_stop_o, .bus_red_o, .bus_green_o, .bus_voltage_fault_o, .supply_loss_fault_o,
	.overcurrent_trip_o, .speed_o);

// *** testbench/drive_run_jog_enable_sequencer_test.sv ***
// self-checking bench for the run/jog/ramp-stop sequencer
`timescale 1ns/1ps
module drive_run_jog_enable_sequencer_test;
	localparam int ES = 0, ST = 1, HO = 2, JG = 3, DG = 4, MS = 5, CO = 6, RR = 7, FR = 8;
	localparam int CH = 10, BL = 11, OV = 12, SL = 13, OC = 14;
	logic clock_i, arst_n_i, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, r;
	logic enable_request_o, drive_enable_o, run_contact_o, digital_mode_o, ramp_stop_o;
	logic run_indicator_o, jog_indicator_o, drive_enable_indicator_o, bus_red_o, bus_green_o;
	logic speed_sensor_indicator_green_o, speed_sensor_indicator_red_o;
	logic bus_voltage_fault_o, supply_loss_fault_o, overcurrent_trip_o;
	logic [11:0] speed_o, rf;
	logic [2:0] commutation_indicator_o;
	logic [19:0] tgt, raw;
	int error_cnt = 0;
	int comparisons = 0;
	// short counts keep ramps and the undervoltage timer inside the run
	drs_sequencer #(.UV_TRIP_CYC(20), .FAST_MIN_STEP(2), .FAST_MAX_STEP(2), .SLOW_MIN_STEP(2),
		.SLOW_MAX_STEP(2)) drs_sequencer_i (.clock_i, .arst_n_i, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .estop_ok_i(raw[ES]), .start_i(raw[ST]),
		.stop_hold_i(raw[HO]), .jog_i(raw[JG]), .digital_mode_i(raw[DG]),
		.mode_select_jumper_i(raw[MS]), .coast_select_jumper_i(raw[CO]),
		.ramp_range_jumper_i(raw[RR]), .fault_reset_jumper_i(raw[9:8]),
		.bus_charged_i(raw[CH]), .bus_low_i(raw[BL]), .bus_over_i(raw[OV]),
		.supply_low_i(raw[SL]), .overcurrent_i(raw[OC]), .commutation_sensor_a_i(raw[15]),
		.commutation_sensor_b_i(raw[16]), .commutation_sensor_c_i(raw[17]),
		.speed_sensor_a_i(raw[18]), .speed_sensor_b_i(raw[19]), .enable_request_o,
		.drive_enable_o, .run_contact_o, .digital_mode_o, .ramp_stop_o, .speed_o,
		.run_indicator_o, .jog_indicator_o, .drive_enable_indicator_o, .bus_red_o,
		.bus_green_o, .commutation_indicator_o, .speed_sensor_indicator_green_o,
		.speed_sensor_indicator_red_o, .bus_voltage_fault_o, .supply_loss_fault_o,
		.overcurrent_trip_o);
	drs_panel drs_panel_i (.clock_i, .want_i(tgt), .raw_o(raw));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			$display("BAD pready expected 1 seen timeout");
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// input filter plus a short ramp
	task automatic settle;
		repeat (3000) @(posedge clock_i);
	endtask : settle
	task automatic mode(input logic [1:0] m);
		apb(1'b0, 8'h0c, 32'h0000_0000);
		chk("mode", m, q[1:0]);
	endtask : mode
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	initial begin
		repeat (90000) @(posedge clock_i);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hc1c7));
		{arst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
		tgt = 20'h0_0000;
		repeat (8) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		chk("enable", 0, drive_enable_o);
		chk("contact", 0, run_contact_o);
		chk("red", 1, bus_red_o);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("time", 32'h0000_8080, q);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("slverr", 1, e);
		tgt[CH] <= 1'b1;
		tgt[RR] <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			tgt[MS] <= r[0];
			tgt[DG] <= r[1];
			tgt[19:15] <= r[6:2];
			settle;
			chk("digital", r[0] | r[1], digital_mode_o);
			chk("comm", r[4:2], commutation_indicator_o);
			chk("tac_g", r[5], speed_sensor_indicator_green_o);
			chk("tac_r", r[6], speed_sensor_indicator_red_o);
		end
		chk("green", 1, bus_green_o);
		tgt[ST] <= 1'b1;
		settle;
		chk("contact", 1, run_contact_o);
		chk("request", 0, enable_request_o);
		tgt[ES] <= 1'b1;
		settle;
		chk("enable", 1, drive_enable_o);
		chk("request", 1, enable_request_o);
		tgt[ST] <= 1'b0;
		settle;
		chk("contact", 0, run_contact_o);
		chk("enable", 0, drive_enable_o);
		chk("ramp", 0, ramp_stop_o);
		r = $urandom;
		rf = 12'h010 + {6'h00, r[5:0]};
		apb(1'b1, 8'h00, {20'h0_0000, rf});
		apb(1'b1, 8'h04, 32'h0000_0008);
		{tgt[CO], tgt[HO], tgt[ST]} <= 3'b111;
		settle;
		tgt[ST] <= 1'b0;
		settle;
		chk("contact", 1, run_contact_o);
		chk("speed", rf, speed_o);
		tgt[JG] <= 1'b1;
		settle;
		chk("jog_ind", 1, jog_indicator_o);
		mode(2'h2);
		tgt[JG] <= 1'b0;
		settle;
		mode(2'h1);
		chk("speed", rf, speed_o);
		tgt[HO] <= 1'b0;
		repeat (2560) @(posedge clock_i);
		chk("ramp", 1, ramp_stop_o);
		chk("enable", 1, drive_enable_o);
		chk("falling", 1, speed_o < rf);
		settle;
		chk("ramp", 0, ramp_stop_o);
		chk("enable", 0, drive_enable_o);
		tgt[JG] <= 1'b1;
		settle;
		chk("run_ind", 0, run_indicator_o);
		chk("jog_ind", 1, jog_indicator_o);
		{tgt[9], tgt[OC], tgt[SL]} <= 3'b111;
		settle;
		{tgt[OC], tgt[SL]} <= 2'b00;
		settle;
		chk("ioc", 1, overcurrent_trip_o);
		chk("pl", 1, supply_loss_fault_o);
		chk("enable", 0, drive_enable_o);
		for (int i = 0; i < 2; i++) begin
			tgt[HO] <= 1'b1;
			settle;
			tgt[HO] <= 1'b0;
			settle;
			chk("ioc", i == 0, overcurrent_trip_o);
			tgt[9] <= 1'b0;
		end
		chk("pl", 0, supply_loss_fault_o);
		chk("enable", 1, drive_enable_o);
		tgt[FR] <= 1'b1;
		settle;
		chk("enable", 0, drive_enable_o);
		tgt[FR] <= 1'b0;
		tgt[BL] <= 1'b1;
		settle;
		chk("uv", 1, bus_voltage_fault_o);
		chk("red", 1, bus_red_o);
		tgt[BL] <= 1'b0;
		tgt[FR] <= 1'b1;
		settle;
		chk("uv", 0, bus_voltage_fault_o);
		tgt[FR] <= 1'b0;
		settle;
		chk("green", 1, bus_green_o);
		chk("enable", 1, drive_enable_o);
		tgt[ES] <= 1'b0;
		settle;
		chk("enable", 0, drive_enable_o);
		chk("request", 0, enable_request_o);
		tally_and_finish;
	end
endmodule : drive_run_jog_enable_sequencer_test
